// file: design/config_port_pin_control.sv
// Configuration port pin controller with synchroniser and byte FIFO
`timescale 1ns/1ns
`include "config_port_pin_control_cfg.svh"

// ----------------------------------------
// Two-flop synchroniser
// ----------------------------------------
module cfg_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;  // First stage, read only by second
  logic [W-1:0] s2_r;  // Second stage
  // Register both stages, pins idle high
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s1_r <= '1;
      s2_r <= '1;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule : cfg_sync

// ----------------------------------------
// Byte FIFO
// ----------------------------------------
module cfg_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];           // Storage
  logic [AW-1:0] wr_r, wr_nxt;       // Write pointer
  logic [AW-1:0] rd_r, rd_nxt;       // Read pointer
  logic [AW:0]   cnt_r, cnt_nxt;     // Fill level
  logic          push, pop;
  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_r];
  // Pointer and level update
  always_comb begin
    wr_nxt  = push ? AW'(wr_r + 1'b1) : wr_r;
    rd_nxt  = pop ? AW'(rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end
  // Register pointers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // Storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule : cfg_fifo

// ----------------------------------------
// Top: configuration port pin control
// ----------------------------------------
module config_port_pin_control
  import config_port_pin_control_pkg::*;
#(
  parameter int LOAD_BYTES = `LOAD_BYTES,
  parameter int USER_IO    = 8
) (
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic [1:0]         cfg_mode,
  input  wire logic               program_request_n,
  input  wire logic               config_ready_n_i,
  output logic                    config_ready_n_o,
  output logic                    config_ready_n_oe,
  input  wire logic               done_i,
  output logic                    done_o,
  output logic                    done_oe,
  input  wire logic               config_clock_i,
  output logic                    config_clock_o,
  output logic                    config_clock_oe,
  input  wire logic               serial_data_a_i,
  output logic                    serial_data_a_o,
  output logic                    serial_data_a_oe,
  input  wire logic               serial_data_b_i,
  output logic                    serial_data_b_o,
  output logic                    serial_data_b_oe,
  output logic                    flash_select_n,
  output logic                    flash_select_n_oe,
  input  wire logic               slave_select_n,
  input  wire logic               io_output_enable,
  input  wire logic [USER_IO-1:0] user_oe_req,
  output logic      [USER_IO-1:0] user_oe,
  output logic                    cfg_valid,
  input  wire logic               cfg_ready,
  output cfg_byte_t               cfg_data,
  output logic                    overflow
);
  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [8:0] raw, syn;
  logic       prog_s, config_clock_s, sda_s, sdb_s, ss_s, toe_s, rdy_s;
  logic [1:0] mode_s;
  assign raw = {program_request_n, config_clock_i, serial_data_a_i, serial_data_b_i,
                slave_select_n, io_output_enable, config_ready_n_i, cfg_mode};
  cfg_sync #(.W(9)) u_sync (.clock(clock), .rst_b(rst_b), .d(raw), .q(syn));
  assign {prog_s, config_clock_s, sda_s, sdb_s, ss_s, toe_s, rdy_s, mode_s} = syn;

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  cfg_state_t st_r, st_nxt;         // Sequence state
  logic [5:0] tmr_r, tmr_nxt;       // Clear timer
  logic [1:0] mode_r, mode_nxt;     // Latched mode
  logic       lock_r, lock_nxt;     // Port locked
  logic       rdy_q_r, config_clock_q_r;    // Previous samples
  logic [7:0] sh_r, sh_nxt;         // Shift register
  logic [2:0] bit_r, bit_nxt;       // Bit in byte
  logic [5:0] mbit_r, mbit_nxt;     // Master command bit
  logic [7:0] nbyte_r, nbyte_nxt;   // Bytes loaded
  logic [1:0] div_r, div_nxt;       // Master clock divider
  logic       mclk_r, mclk_nxt;     // Master clock level
  logic       ovf_r, ovf_nxt;       // Slave overrun
  logic       rdy_rise, config_clock_rise, tick, master;
  logic       push, in_ready, shift_in, byte_end;
  cfg_byte_t  push_data;

  assign rdy_rise  = rdy_s && !rdy_q_r;
  assign config_clock_rise = config_clock_s && !config_clock_q_r;
  assign master    = (mode_r == `MODE_MASTER_SPI);
  // Divider pulse, held back while FIFO is full
  assign tick      = (div_r == 2'(`MCLK_DIV - 1)) && in_ready;
  assign byte_end  = (bit_r == 3'h7);
  assign push_data = {sh_r[6:0], shift_in};

  // Sampling point and bit source per mode
  always_comb begin
    shift_in = sda_s;
    push     = 1'b0;
    if (st_r == ST_LOAD) begin
      if (master) begin
        shift_in = sdb_s;
        push = tick && !mclk_r && (mbit_r == 6'(`MASTER_CMD_BITS)) && byte_end;
      end else begin
        push = config_clock_rise && !ss_s && byte_end;
      end
    end
  end

  // Next-state computation
  always_comb begin
    st_nxt    = st_r;
    tmr_nxt   = tmr_r;
    mode_nxt  = mode_r;
    lock_nxt  = lock_r;
    sh_nxt    = sh_r;
    bit_nxt   = bit_r;
    mbit_nxt  = mbit_r;
    nbyte_nxt = nbyte_r;
    div_nxt   = (div_r == 2'(`MCLK_DIV - 1)) ? 2'h0 : 2'(div_r + 1'b1);
    mclk_nxt  = mclk_r;
    ovf_nxt   = ovf_r;
    case (st_r)
      ST_CLEAR: begin
        // Hold ready low for the clear time
        if (tmr_r != '0) begin
          tmr_nxt = 6'(tmr_r - 1'b1);
        end else begin
          st_nxt = ST_WAIT_READY;
        end
      end
      ST_WAIT_READY: begin
        // Ready released; host may hold it low longer
        if (rdy_rise) begin
          if (!lock_r) begin
            mode_nxt = mode_s;
            lock_nxt = 1'b1;
          end
          st_nxt = ((lock_r ? mode_r : mode_s) > `MODE_MASTER_SPI) ? ST_ERROR : ST_LOAD;
          sh_nxt = `FLASH_READ_CMD;
          bit_nxt = '0;
          mbit_nxt = '0;
          nbyte_nxt = '0;
          mclk_nxt = 1'b0;
        end
      end
      ST_LOAD: begin
        if (master) begin
          if (tick) begin
            mclk_nxt = !mclk_r;
            if (mclk_r && mbit_r != 6'(`MASTER_CMD_BITS)) begin
              // Falling edge: next command bit out
              mbit_nxt = 6'(mbit_r + 1'b1);
              sh_nxt = {sh_r[6:0], 1'b0};
            end else if (!mclk_r && mbit_r == 6'(`MASTER_CMD_BITS)) begin
              sh_nxt = push_data;
              bit_nxt = 3'(bit_r + 1'b1);
            end
          end
        end else if (config_clock_rise && !ss_s) begin
          sh_nxt = push_data;
          bit_nxt = 3'(bit_r + 1'b1);
          if (byte_end && !in_ready) begin
            ovf_nxt = 1'b1;
          end
        end
        if (push || (byte_end && config_clock_rise && !ss_s && !master)) begin
          nbyte_nxt = 8'(nbyte_r + 1'b1);
          if (nbyte_r == 8'(LOAD_BYTES - 1)) begin
            st_nxt = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        mclk_nxt = 1'b0;
      end
      ST_ERROR: begin
        mclk_nxt = 1'b0;
      end
      default: begin
        st_nxt = ST_CLEAR;
      end
    endcase
    // Program request overrides every state
    if (!prog_s) begin
      st_nxt  = ST_CLEAR;
      tmr_nxt = 6'(`INIT_CLEAR_CYC);
      ovf_nxt = 1'b0;
    end
  end

  // Register control state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r     <= ST_CLEAR;
      tmr_r    <= 6'(`INIT_CLEAR_CYC);
      mode_r   <= `MODE_SLAVE_SPI;
      lock_r   <= 1'b0;
      rdy_q_r  <= 1'b1;
      config_clock_q_r <= 1'b1;
      sh_r     <= '0;
      bit_r    <= '0;
      mbit_r   <= '0;
      nbyte_r  <= '0;
      div_r    <= '0;
      mclk_r   <= 1'b0;
      ovf_r    <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      tmr_r    <= tmr_nxt;
      mode_r   <= mode_nxt;
      lock_r   <= lock_nxt;
      rdy_q_r  <= rdy_s;
      config_clock_q_r <= config_clock_s;
      sh_r     <= sh_nxt;
      bit_r    <= bit_nxt;
      mbit_r   <= mbit_nxt;
      nbyte_r  <= nbyte_nxt;
      div_r    <= div_nxt;
      mclk_r   <= mclk_nxt;
      ovf_r    <= ovf_nxt;
    end
  end

  // ----------------------------------------
  // Data buffer
  // ----------------------------------------
  cfg_fifo #(.W(8), .D(`FIFO_DEPTH)) u_fifo (
    .clock(clock), .rst_b(rst_b),
    .in_valid(push), .in_ready(in_ready), .in_data(push_data),
    .out_valid(cfg_valid), .out_ready(cfg_ready), .out_data(cfg_data)
  );

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  pin_drive_t rdy_d, done_d, config_clock_d, sda_d, sdb_d, fcs_d;
  logic       loading;
  assign loading = (st_r == ST_LOAD);
  assign rdy_d   = '{o: 1'b0, oe: (st_r == ST_CLEAR) || (st_r == ST_ERROR)};
  assign done_d  = '{o: 1'b0, oe: (st_r != ST_DONE)};
  assign config_clock_d  = '{o: mclk_r, oe: loading && master};
  assign sda_d   = '{o: sh_r[7], oe: loading && master};
  assign sdb_d   = '{o: sh_r[7], oe: loading && !master && !ss_s};
  assign fcs_d   = '{o: !(loading && master), oe: master && lock_r};
  // Low output enable forces every driver off
  assign config_ready_n_o  = rdy_d.o;
  assign config_ready_n_oe = rdy_d.oe && toe_s;
  assign done_o            = done_d.o;
  assign done_oe           = done_d.oe && toe_s;
  assign config_clock_o    = config_clock_d.o;
  assign config_clock_oe   = config_clock_d.oe && toe_s;
  assign serial_data_a_o   = sda_d.o;
  assign serial_data_a_oe  = sda_d.oe && toe_s;
  assign serial_data_b_o   = sdb_d.o;
  assign serial_data_b_oe  = sdb_d.oe && toe_s;
  assign flash_select_n    = fcs_d.o;
  assign flash_select_n_oe = fcs_d.oe && toe_s;
  assign user_oe           = toe_s ? user_oe_req : '0;
  assign overflow          = ovf_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_rise_unlocked; rdy_rise && !lock_r && st_r == ST_WAIT_READY && prog_s; endsequence
  a_mode_latch_value: assert property (s_rise_unlocked |=> mode_r == $past(mode_s) && lock_r)
    else $error("mode not latched at ready rise");
  a_prog_restart: assert property (!prog_s |=> st_r == ST_CLEAR ##1 config_ready_n_oe || !toe_s)
    else $error("program request did not restart");
  a_ready_low_clear: assert property (st_r == ST_CLEAR && toe_s |-> config_ready_n_oe)
    else $error("ready not held low while clearing");
  a_done_release: assert property (toe_s |-> ((st_r == ST_DONE) iff !done_oe))
    else $error("done pin wrong for state");
  a_master_clock_pace: assert property (loading && master && tick |=> mclk_r != $past(mclk_r))
    else $error("master clock not paced by divider");
  a_data_a_dir: assert property (serial_data_a_oe |-> master && loading)
    else $error("data pin A driven outside master load");
  a_data_b_dir: assert property (serial_data_b_oe |-> !master && !ss_s)
    else $error("data pin B driven wrongly");
  a_flash_select: assert property (loading && master && toe_s |-> !flash_select_n && flash_select_n_oe)
    else $error("flash not selected in master load");
  a_slave_ignore: assert property (loading && !master && ss_s |=> $stable(bit_r))
    else $error("slave shifted while deselected");
  a_toe_tristate: assert property (!toe_s |-> !done_oe && !config_clock_oe && user_oe == '0)
    else $error("pins driven while tristated");
  a_port_locked: assert property (lock_r |=> lock_r && $stable(mode_r))
    else $error("locked port changed");
endmodule : config_port_pin_control

// file: inc/config_port_pin_control_cfg.svh
// Constants of the configuration port pin controller
`ifndef CONFIG_PORT_PIN_CONTROL_CFG_SVH
`define CONFIG_PORT_PIN_CONTROL_CFG_SVH
`define CLK_PERIOD_NS   40
`define INIT_CLEAR_NS   1000
`define INIT_CLEAR_CYC  ((`INIT_CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_SLAVE_SPI  2'h0
`define MODE_MASTER_SPI 2'h1
`define FLASH_READ_CMD  8'h03
`define MASTER_CMD_BITS 32
`define MCLK_DIV        4
`define LOAD_BYTES      16
`define FIFO_DEPTH      16
`endif

// file: inc/config_port_pin_control_pkg.sv
// Types of the configuration port pin controller
package config_port_pin_control_pkg;
  typedef enum logic [2:0] {
    ST_CLEAR, ST_WAIT_READY, ST_LOAD, ST_DONE, ST_ERROR
  } cfg_state_t;
  typedef struct packed {
    logic o;   // Level driven
    logic oe;  // Drive enable
  } pin_drive_t;
  typedef logic [7:0] cfg_byte_t;
endpackage : config_port_pin_control_pkg

// file: verification/cfg_host_model.sv
// Far side model: slave SPI host and master SPI flash
`timescale 1ns/1ns
module cfg_host_model
  import config_port_pin_control_pkg::*;
(
  input  wire logic config_clock_w,    // Config clock on the wire
  input  wire logic sda_w,     // Data pin A on the wire
  input  wire logic cs_n_w,    // Flash select on the wire, pulled up
  output logic      host_clk,  // Host clock, still outside frames
  output logic      host_a,    // Host data into pin A
  output logic      host_b,    // Flash data into pin B
  output logic      sel_n      // Slave select, low selects
);
  logic [31:0] cmd_bits;   // Command seen by the flash
  int          bit_count;  // Rising clocks in this frame
  initial begin
    host_clk  = 1'b0;
    host_a    = 1'b0;
    host_b    = 1'b0;
    sel_n     = 1'b1;
    cmd_bits  = 32'h0;
    bit_count = 0;
  end
  // -------------------------------------
  // Slave host
  // -------------------------------------
  // One byte MSB first; never any boundary-scan traffic here
  task automatic send_byte(input cfg_byte_t v, input logic sel);
    sel_n = !sel;
    for (int i = 7; i >= 0; i--) begin
      host_a = v[i];
      #160 host_clk = 1'b1;
      #160 host_clk = 1'b0;
    end
    #160 sel_n = 1'b1;
    host_a = ~host_a;  // Released line shows no stale bit
    #40;  // One idle cycle before the next frame
  endtask : send_byte
  // -------------------------------------
  // Flash
  // -------------------------------------
  // Pattern byte 40h plus index, MSB first
  function automatic logic flash_bit(input int pos);
    cfg_byte_t pat;
    pat = 8'h40 + 8'(pos / 8);
    return pat[7 - pos % 8];
  endfunction : flash_bit
  // Command bits taken on rising clock
  always @(posedge config_clock_w) begin
    if (!cs_n_w) begin
      if (bit_count < 32) cmd_bits <= {cmd_bits[30:0], sda_w};
      bit_count <= bit_count + 1;
    end
  end
  // Data bit changes on falling clock
  always @(negedge config_clock_w) begin
    if (!cs_n_w && bit_count >= 32) host_b <= flash_bit(bit_count - 32);
  end
  // Deselect: line released, count restarts
  always @(posedge cs_n_w) begin
    host_b    <= ~host_b;
    bit_count <= 0;
  end
endmodule : cfg_host_model

// file: verification/config_port_pin_control_test.sv
// Self-checking bench of the configuration port pin controller
`timescale 1ns/1ns
`include "config_port_pin_control_cfg.svh"
module config_port_pin_control_test;
  import config_port_pin_control_pkg::*;
  // -------------------------------------
  // Signals
  // -------------------------------------
  localparam int LOADN = 18;  // Past the FIFO depth
  logic       clock, rst_b, program_request_n, io_output_enable, cfg_ready;
  logic [1:0] cfg_mode;
  logic [7:0] user_oe_req, user_oe;
  logic       config_ready_n_o, config_ready_n_oe, done_o, done_oe;
  logic       config_clock_o, config_clock_oe, serial_data_a_o, serial_data_a_oe;
  logic       serial_data_b_o, serial_data_b_oe, flash_select_n, flash_select_n_oe;
  logic       cfg_valid, overflow;
  cfg_byte_t  cfg_data;
  wire logic  ready_w, done_w, config_clock_w, sda_w, sdb_w, cs_n_w, host_clk, host_a, host_b, sel_n;
  int         fails, tests_run, cycles;
  // Open-drain pins pulled up, shared pins resolved
  assign ready_w = config_ready_n_oe ? config_ready_n_o : 1'b1;
  assign done_w  = done_oe ? done_o : 1'b1;
  assign config_clock_w  = config_clock_oe ? config_clock_o : host_clk;
  assign sda_w   = serial_data_a_oe ? serial_data_a_o : host_a;
  assign sdb_w   = serial_data_b_oe ? serial_data_b_o : host_b;
  assign cs_n_w  = flash_select_n_oe ? flash_select_n : 1'b1;
  config_port_pin_control #(.LOAD_BYTES(LOADN), .USER_IO(8)) config_port_pin_control_i (
    .clock(clock), .rst_b(rst_b), .cfg_mode(cfg_mode), .program_request_n(program_request_n),
    .config_ready_n_i(ready_w), .config_ready_n_o(config_ready_n_o),
    .config_ready_n_oe(config_ready_n_oe), .done_i(done_w), .done_o(done_o),
    .done_oe(done_oe), .config_clock_i(config_clock_w), .config_clock_o(config_clock_o),
    .config_clock_oe(config_clock_oe), .serial_data_a_i(sda_w),
    .serial_data_a_o(serial_data_a_o), .serial_data_a_oe(serial_data_a_oe),
    .serial_data_b_i(sdb_w), .serial_data_b_o(serial_data_b_o),
    .serial_data_b_oe(serial_data_b_oe), .flash_select_n(flash_select_n),
    .flash_select_n_oe(flash_select_n_oe), .slave_select_n(sel_n),
    .io_output_enable(io_output_enable), .user_oe_req(user_oe_req), .user_oe(user_oe),
    .cfg_valid(cfg_valid), .cfg_ready(cfg_ready), .cfg_data(cfg_data), .overflow(overflow));
  cfg_host_model cfg_host_model_i (.config_clock_w(config_clock_w), .sda_w(sda_w), .cs_n_w(cs_n_w),
    .host_clk(host_clk), .host_a(host_a), .host_b(host_b),
    .sel_n(sel_n));
  // -------------------------------------
  // Shared tasks
  // -------------------------------------
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic test_done();
    $display("Checks made %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic do_reset(input logic [1:0] mode);
    rst_b = 1'b0;
    cfg_mode = mode;
    tick(3);
    rst_b = 1'b1;
    tick(1);
  endtask : do_reset
  // Wait for the ready pin to be let go, then for the mode latch
  task automatic wait_release();
    int n;
    n = 0;
    while (config_ready_n_oe !== 1'b0 && n < 80) begin
      tick(1);
      n++;
    end
    check("ready released", config_ready_n_oe, 1'b0);
    tick(4);
  endtask : wait_release
  // Take n bytes off the stream, value base plus index
  task automatic drain(input int first, input int n, input cfg_byte_t base);
    int w;
    for (int k = first; k < first + n; k++) begin
      w = 0;
      while (cfg_valid !== 1'b1 && w < 3000) begin
        tick(1);
        w++;
      end
      check("stream byte", cfg_data, base + 8'(k));
      cfg_ready = 1'b1;
      tick(1);
      cfg_ready = 1'b0;
      tick(1);
    end
  endtask : drain
  // -------------------------------------
  // Scenarios
  // -------------------------------------
  task automatic test_power_up();
    do_reset(`MODE_SLAVE_SPI);
    check("done held", done_oe, 1'b1);
    tick(20);
    check("ready held", config_ready_n_oe, 1'b1);
    check("ready pin level", ready_w, 1'b0);
    check("done pin level", done_w, 1'b0);
    wait_release();
    check("flash select oe", flash_select_n_oe, 1'b0);
    check("pin A oe", serial_data_a_oe, 1'b0);
    $display("power up test ended");
  endtask : test_power_up
  task automatic test_slave_load();
    cfg_host_model_i.send_byte(8'hEE, 1'b0);  // Ignored, not selected
    fork
      cfg_host_model_i.send_byte(8'h00, 1'b1);
      begin
        tick(20);
        check("pin B oe", serial_data_b_oe, 1'b1);
      end
    join
    for (int i = 1; i < 17; i++) cfg_host_model_i.send_byte(8'(i), 1'b1);
    tick(6);
    check("overflow", overflow, 1'b1);
    check("done not yet", done_oe, 1'b1);
    drain(0, 16, 8'h00);
    cfg_host_model_i.send_byte(8'h11, 1'b1);
    tick(6);
    check("done released", done_oe, 1'b0);
    drain(17, 1, 8'h00);
    $display("slave load test ended");
  endtask : test_slave_load
  task automatic test_reprogram();
    cfg_mode = `MODE_MASTER_SPI;
    program_request_n = 1'b0;
    tick(4);
    check("ready pulled", config_ready_n_oe, 1'b1);
    check("done pulled", done_oe, 1'b1);
    check("overflow cleared", overflow, 1'b0);
    program_request_n = 1'b1;
    wait_release();
    check("mode locked", flash_select_n_oe, 1'b0);
    check("clock not driven", config_clock_oe, 1'b0);
    $display("reprogram test ended");
  endtask : test_reprogram
  task automatic test_master_load();
    int w;
    do_reset(`MODE_MASTER_SPI);
    io_output_enable = 1'b0;
    tick(4);
    check("ready tristated", config_ready_n_oe, 1'b0);
    check("done tristated", done_oe, 1'b0);
    check("user tristated", user_oe, 8'h00);
    io_output_enable = 1'b1;
    tick(4);
    check("user passed", user_oe, 8'hA5);
    wait_release();
    w = 0;
    while (cfg_host_model_i.bit_count < 160 && w < 4000) begin
      tick(1);
      w++;
    end
    tick(100);
    check("flash selected", flash_select_n, 1'b0);
    check("clock paused", cfg_host_model_i.bit_count, `MASTER_CMD_BITS + 8 * `FIFO_DEPTH);
    check("read command", cfg_host_model_i.cmd_bits, {`FLASH_READ_CMD, 24'h0});
    drain(0, LOADN, 8'h40);
    tick(20);
    check("flash released", flash_select_n, 1'b1);
    check("master done", done_oe, 1'b0);
    $display("master load test ended");
  endtask : test_master_load
  // Unsupported mode code holds ready low after the latch
  task automatic test_bad_mode();
    do_reset(2'h2);
    wait_release();
    check("ready held on bad mode", config_ready_n_oe, 1'b1);
    check("done held on bad mode", done_oe, 1'b1);
    check("no flash select", flash_select_n_oe, 1'b0);
    $display("bad mode test ended");
  endtask : test_bad_mode
  // -------------------------------------
  // Clock, timeout and main sequence
  // -------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Hang guard well above the expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    rst_b = 1'b0;
    cfg_mode = `MODE_SLAVE_SPI;
    program_request_n = 1'b1;
    io_output_enable = 1'b1;
    user_oe_req = 8'hA5;
    cfg_ready = 1'b0;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    test_power_up();
    test_slave_load();
    test_reprogram();
    test_master_load();
    test_bad_mode();
    test_done();
  end
endmodule : config_port_pin_control_test
